// ---- tb/pdslc_rc_model.sv ----
// Root complex model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pdslc_rc_model (
   input wire logic clk_in,
   output logic rd_out,
   output logic wr_out,
   output logic [11:0] addr_out,
   output logic [3:0] be_out,
   output logic [31:0] wdata_out
);
   initial {rd_out, wr_out, addr_out, be_out, wdata_out} = '0;
   // Request held for one edge; on release rd_out and wr_out drop to zero and the other lines show the inverse of their last value
   task automatic req(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge clk_in);
      {rd_out, wr_out, addr_out, be_out, wdata_out} = {~w, w, a, b, d};
      @(negedge clk_in);
      {rd_out, wr_out, addr_out, be_out, wdata_out} = {2'b00, ~a, ~b, ~d};
   endtask
endmodule // pdslc_rc_model
`default_nettype wire

// ---- tb/pdslc_regs_checker.sv ----
// Assertions on the configuration register block ports
`timescale 1ns/1ps
`default_nettype none
module pdslc_regs_checker import pdslc_pkg::*; (
   input wire logic clk_in, rst_b_in, cfg_rd_in, cfg_rvalid_out, common_clock_cfg_in,
   input wire logic [11:0] cfg_addr_in,
   input wire logic [31:0] cfg_rdata_out,
   input wire logic [2:0] l1_exit_sel_a_in, l1_exit_sel_b_in,
   input wire logic unsupported_req_in, fatal_err_in, nonfatal_err_in, correctable_err_in,
   input wire logic err_nonfatal_msg_out, err_cor_msg_out, nonfatal_report_en_out,
   input wire logic correctable_report_en_out, unsupported_req_report_en_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence caps_rd; cfg_rd_in && cfg_addr_in[11:2] == LINK_CAPS_OFS[11:2]; endsequence
   sequence stat_rd; cfg_rd_in && cfg_addr_in[11:2] == DEV_STATUS_OFS[11:2]; endsequence
   sequence all_err; fatal_err_in && unsupported_req_in && nonfatal_err_in && correctable_err_in; endsequence
   chk_caps_fixed: assert property (caps_rd |=> cfg_rdata_out[31:18] == 14'h0001 &&
      cfg_rdata_out[11:0] == 12'hc11) else $error("link caps constant fields wrong");
   chk_l0s_select: assert property (caps_rd |=> cfg_rdata_out[14:12] ==
      ($past(common_clock_cfg_in) ? L0S_LAT_COMMON : L0S_LAT_ASYNC)) else $error("L0s_exit_latency wrong");
   chk_l1_mirror: assert property (caps_rd |=> cfg_rdata_out[17:15] == ($past(common_clock_cfg_in) ?
      $past(l1_exit_sel_a_in) : $past(l1_exit_sel_b_in))) else $error("L1_exit_latency wrong");
   chk_status_rsvd: assert property (stat_rd |=> cfg_rdata_out[31:22] == 10'h000)
      else $error("status reserved bits not zero");
   chk_error_flags: assert property (all_err ##1 stat_rd |=> cfg_rdata_out[19:16] == 4'hf)
      else $error("error flags not set");
   chk_cor_msg: assert property (err_cor_msg_out == $past(correctable_err_in && correctable_report_en_out))
      else $error("correctable message mismatch");
   chk_nf_msg: assert property (err_nonfatal_msg_out == $past(nonfatal_err_in && nonfatal_report_en_out ||
      unsupported_req_in && unsupported_req_report_en_out)) else $error("nonfatal message mismatch");
   chk_unmapped_zero: assert property (cfg_rd_in && cfg_addr_in[11:3] != DEV_CONTROL_OFS[11:3]
      |=> cfg_rvalid_out && cfg_rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
endmodule // pdslc_regs_checker
bind pdslc_regs pdslc_regs_checker chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
   import pdslc_pkg::*;
   logic clk_in = 0, rst_b_in = 0, common_clock_cfg_in = 0, aux_power_pin_in = 0, np_outstanding_in = 0;
   logic unsupported_req_in = 0, fatal_err_in = 0, nonfatal_err_in = 0, correctable_err_in = 0;
   logic cfg_rd_in, cfg_wr_in, cfg_rvalid_out, err_nonfatal_msg_out, err_cor_msg_out;
   logic nonfatal_report_en_out, correctable_report_en_out, unsupported_req_report_en_out;
   logic [2:0] l1_exit_sel_a_in = 0, l1_exit_sel_b_in = 0;
   logic [11:0] cfg_addr_in;
   logic [3:0] cfg_be_in, en;
   logic [31:0] cfg_wdata_in, cfg_rdata_out, wd, ctl, want;
   logic [31:0] q[$];
   int fails = 0, checks_done = 0;
   assign en = {unsupported_req_report_en_out, 1'b0, nonfatal_report_en_out, correctable_report_en_out};
   always #4 clk_in = ~clk_in;
   pdslc_rc_model rc (.clk_in(clk_in), .rd_out(cfg_rd_in), .wr_out(cfg_wr_in),
      .addr_out(cfg_addr_in), .be_out(cfg_be_in), .wdata_out(cfg_wdata_in));
   pdslc_regs dut (.*);
   // Each read answer is matched against the oldest expectation
   always @(negedge clk_in) begin
      if (cfg_rvalid_out === 1'b1) begin
         want = q.size() ? q.pop_front() : 'x;
         `CHK(cfg_rdata_out, want)
      end
   end
   task automatic rdx(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      rc.req(1'b0, a, 4'h0, $urandom);
   endtask
   task automatic summarize;
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_in);
      fails++;
      summarize;
   end
   initial begin
      void'($urandom(32'h48fc));
      repeat (4) @(negedge clk_in);
      rst_b_in = 1;
      rdx(DEV_CONTROL_OFS, 32'h0);
      rdx(12'h0f0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         common_clock_cfg_in = i[0];
         l1_exit_sel_a_in = 3'($urandom);
         l1_exit_sel_b_in = 3'($urandom);
         rdx(LINK_CAPS_OFS, {14'h0001, i[0] ? l1_exit_sel_a_in : l1_exit_sel_b_in,
            i[0] ? L0S_LAT_COMMON : L0S_LAT_ASYNC, 12'hc11});
      end
      $display("Test reset and link caps done");
      wd = $urandom;
      ctl = wd & 32'h0000_000b;
      rc.req(1'b1, DEV_CONTROL_OFS, 4'h1, wd);
      `CHK(en, ctl[3:0])
      aux_power_pin_in = 1;
      np_outstanding_in = 1;
      {unsupported_req_in, fatal_err_in, nonfatal_err_in, correctable_err_in} = 4'hf;
      fork
         rdx(DEV_CONTROL_OFS, ctl | 32'h002f_0000);
         begin @(negedge clk_in); {unsupported_req_in, fatal_err_in, nonfatal_err_in, correctable_err_in} = 4'h0; end
      join
      rc.req(1'b1, DEV_CONTROL_OFS, 4'h4, 32'h0);
      rdx(DEV_CONTROL_OFS, ctl | 32'h003f_0000);
      rc.req(1'b1, DEV_CONTROL_OFS, 4'h4, 32'h0005_0000);
      rdx(DEV_CONTROL_OFS, ctl | 32'h003a_0000);
      np_outstanding_in = 0;
      aux_power_pin_in = 0;
      repeat (3) @(negedge clk_in);
      rdx(DEV_CONTROL_OFS, ctl | 32'h000a_0000);
      repeat (3) @(negedge clk_in);
      `CHK(q.size(), 0)
      $display("Test status flags done");
      rc.req(1'b1, DEV_CONTROL_OFS, 4'h1, 32'h0000_000b);
      {nonfatal_err_in, correctable_err_in} = 2'b11;
      @(negedge clk_in);
      `CHK({err_nonfatal_msg_out, err_cor_msg_out}, 2'b11)
      {nonfatal_err_in, correctable_err_in, unsupported_req_in} = 3'b001;
      @(negedge clk_in);
      `CHK({err_nonfatal_msg_out, err_cor_msg_out}, 2'b10)
      unsupported_req_in = 0;
      rc.req(1'b1, DEV_CONTROL_OFS, 4'h1, 32'h0);
      {nonfatal_err_in, correctable_err_in, unsupported_req_in} = 3'b111;
      @(negedge clk_in);
      `CHK({err_nonfatal_msg_out, err_cor_msg_out}, 2'b00)
      {nonfatal_err_in, correctable_err_in, unsupported_req_in} = 3'b000;
      $display("Test messages done");
      summarize;
   end
endmodule // testbench
`default_nettype wire

// ---- verilog/pdslc_pkg.sv ----
// Constants for the device control, device status and link capabilities registers
`default_nettype none
package pdslc_pkg;
   // Configuration space byte offsets
   localparam logic [11:0] DEV_CONTROL_OFS = 12'h078;
   localparam logic [11:0] DEV_STATUS_OFS = 12'h07a;
   localparam logic [11:0] LINK_CAPS_OFS = 12'h07c;
   localparam int CFG_ADDR_W = 12;
   localparam int CFG_DATA_W = 32;
   localparam int CFG_BE_W = 4;
   // Lane of the dword at 0x78 that holds the status word
   localparam int STATUS_LANE_LSB = 16;
   localparam int STATUS_BE_IDX = 2;
   localparam int CONTROL_BE_IDX = 0;
   // Device control fields
   localparam int CORR_REPORT_EN_BIT = 0;
   localparam int NONFATAL_REPORT_EN_BIT = 1;
   localparam int UR_REPORT_EN_BIT = 3;
   localparam logic [15:0] DEV_CONTROL_RESET = 16'h0000;
   // Device status fields
   localparam int CORR_DET_BIT = 0;
   localparam int NONFATAL_DET_BIT = 1;
   localparam int FATAL_DET_BIT = 2;
   localparam int UR_DET_BIT = 3;
   localparam int AUX_PWR_BIT = 4;
   localparam int TXN_TXN_PENDING_BIT = 5;
   localparam logic [15:0] DEV_STATUS_RESET = 16'h0000;
   localparam logic [9:0] STATUS_RSVD_VAL = 10'h000;
   // Link capabilities fields
   localparam logic [7:0] PORT_NUM_VAL = 8'h00;
   localparam logic [1:0] CAPS_RSVD_VAL = 2'h0;
   localparam logic BW_NOTIFY_CAPABLE = 1'b0;
   localparam logic LINK_ACTIVE_REPORT_CAPABLE = 1'b0;
   localparam logic SURPRISE_DOWN_CAPABLE = 1'b0;
   localparam logic CLOCK_PM_CAPABLE = 1'b1;
   localparam logic [2:0] L0S_LAT_COMMON = 3'h3;
   localparam logic [2:0] L0S_LAT_ASYNC = 3'h4;
   localparam logic [1:0] ASPM_SUPPORT_VAL = 2'h3;
   localparam logic [5:0] MAX_LINK_WIDTH_VAL = 6'h01;
   localparam logic [3:0] MAX_LINK_SPEED_VAL = 4'h1;
endpackage
`default_nettype wire

// ---- verilog/pdslc_regs.sv ----
// Device control error enables, device status and link capabilities registers
// Notes on behaviour
// [R1] Nonfatal enable set allows nonfatal error messages
// [R2] Correctable enable set allows correctable error messages
// [R3] Pending bit follows outstanding non-posted transactions
// [R4] Aux power bit shows detected auxiliary power
// [R5] Unsupported request always sets its detected flag
// [R6] Fatal error sets fatal detected flag
// [R7] Nonfatal error sets nonfatal detected flag
// [R8] Correctable error sets correctable detected flag
// [R9] Detected flags clear only by writing one
// [R10] Status upper bits read zero; resets zero
// [R11] Port number and reserved bits read zero
// [R12] Bandwidth, link-active, surprise-down capabilities read zero
// [R13] Clock power management capability reads one
// [R14] L1_exit_latency mirrors diagnostic field chosen by clocking
// [R15] L0s_exit_latency 011b common, 100b asynchronous
// [R16] ASPM support field reads 11b
// [R17] Maximum link width reads single lane
// [R18] Maximum link speed reads 2.5 Gb/s
// [R19] Common clock bit selects reported latencies
// [R20] Unsupported request reporting enable adds nonfatal message
`timescale 1ns/1ps
`default_nettype none
module pdslc_regs (
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Configuration access, dword aligned byte address
   input wire logic cfg_rd_in,
   input wire logic cfg_wr_in,
   input wire logic [pdslc_pkg::CFG_ADDR_W-1:0] cfg_addr_in,
   input wire logic [pdslc_pkg::CFG_BE_W-1:0] cfg_be_in,
   input wire logic [pdslc_pkg::CFG_DATA_W-1:0] cfg_wdata_in,
   output logic [pdslc_pkg::CFG_DATA_W-1:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   // Device events from core logic
   input wire logic unsupported_req_in,
   input wire logic fatal_err_in,
   input wire logic nonfatal_err_in,
   input wire logic correctable_err_in,
   input wire logic np_outstanding_in,
   // Auxiliary power sense pin
   input wire logic aux_power_pin_in,
   // Link settings held elsewhere in configuration space
   input wire logic common_clock_cfg_in,
   input wire logic [2:0] l1_exit_sel_a_in,
   input wire logic [2:0] l1_exit_sel_b_in,
   // Error message requests toward the upstream message generator
   output logic err_nonfatal_msg_out,
   output logic err_cor_msg_out,
   // Enables for other logic
   output logic nonfatal_report_en_out,
   output logic correctable_report_en_out,
   output logic unsupported_req_report_en_out
);
   import pdslc_pkg::*;

   logic nonfatal_report_en_q;
   logic correctable_report_en_q;
   logic unsupported_req_report_en_q;
   // Detected flags, indexed by their status bit positions
   localparam int NUM_FLAGS = 4;
   logic [NUM_FLAGS-1:0] err_flags_q;
   logic txn_pending_q;
   logic aux_meta_q;
   logic aux_power_detected_q;
   logic err_nonfatal_msg_q;
   logic err_cor_msg_q;
   logic [CFG_DATA_W-1:0] rdata_q;
   logic rvalid_q;

   // Address decode
   wire logic hit_ctl_sts = (cfg_addr_in[CFG_ADDR_W-1:2] == DEV_CONTROL_OFS[CFG_ADDR_W-1:2]);
   wire logic hit_caps = (cfg_addr_in[CFG_ADDR_W-1:2] == LINK_CAPS_OFS[CFG_ADDR_W-1:2]);
   wire logic ctl_wr = cfg_wr_in & hit_ctl_sts & cfg_be_in[CONTROL_BE_IDX];
   wire logic sts_wr = cfg_wr_in & hit_ctl_sts & cfg_be_in[STATUS_BE_IDX];
   wire logic [15:0] sts_wdata = cfg_wdata_in[STATUS_LANE_LSB +: 16];

   // Write-one-to-clear strobes; a new event wins over the clear
   wire logic [NUM_FLAGS-1:0] flag_event = {unsupported_req_in, fatal_err_in, nonfatal_err_in,
      correctable_err_in};
   wire logic [NUM_FLAGS-1:0] flag_clr = {NUM_FLAGS{sts_wr}} & sts_wdata[UR_DET_BIT:CORR_DET_BIT]; // R9

   // One sticky flag per error kind
   for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            err_flags_q[i] <= DEV_STATUS_RESET[CORR_DET_BIT + i];
         end else begin
            err_flags_q[i] <= flag_event[i] | (err_flags_q[i] & ~flag_clr[i]); // R5 R6 R7 R8
         end
      end
   end

   // Message requests
   wire logic nonfatal_msg_d = (nonfatal_report_en_q & nonfatal_err_in) // R1
      | (unsupported_req_report_en_q & unsupported_req_in); // R20
   wire logic cor_msg_d = correctable_report_en_q & correctable_err_in; // R2

   // Register images
   wire logic [15:0] dev_control_img = {12'h000, unsupported_req_report_en_q, 1'b0,
      nonfatal_report_en_q, correctable_report_en_q};
   wire logic [15:0] dev_status_img = {STATUS_RSVD_VAL, txn_pending_q, aux_power_detected_q,
      err_flags_q}; // R10
   wire logic [2:0] l1_exit_latency = common_clock_cfg_in ? l1_exit_sel_a_in
      : l1_exit_sel_b_in; // R14 R19
   wire logic [2:0] l0s_exit_latency = common_clock_cfg_in ? L0S_LAT_COMMON
      : L0S_LAT_ASYNC; // R15 R19
   wire logic [31:0] link_caps_img = {PORT_NUM_VAL, CAPS_RSVD_VAL, // R11
      BW_NOTIFY_CAPABLE, LINK_ACTIVE_REPORT_CAPABLE, SURPRISE_DOWN_CAPABLE, // R12
      CLOCK_PM_CAPABLE, // R13
      l1_exit_latency, l0s_exit_latency,
      ASPM_SUPPORT_VAL, // R16
      MAX_LINK_WIDTH_VAL, // R17
      MAX_LINK_SPEED_VAL}; // R18
   wire logic [31:0] rdata_d = hit_ctl_sts ? {dev_status_img, dev_control_img}
      : hit_caps ? link_caps_img : 32'h0000_0000;

   // Device control enables
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nonfatal_report_en_q <= DEV_CONTROL_RESET[NONFATAL_REPORT_EN_BIT];
         correctable_report_en_q <= DEV_CONTROL_RESET[CORR_REPORT_EN_BIT];
         unsupported_req_report_en_q <= DEV_CONTROL_RESET[UR_REPORT_EN_BIT];
      end else if (ctl_wr) begin
         nonfatal_report_en_q <= cfg_wdata_in[NONFATAL_REPORT_EN_BIT]; // R1
         correctable_report_en_q <= cfg_wdata_in[CORR_REPORT_EN_BIT]; // R2
         unsupported_req_report_en_q <= cfg_wdata_in[UR_REPORT_EN_BIT]; // R20
      end
   end

   // Status flags; pending and aux power ignore writes
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         txn_pending_q <= DEV_STATUS_RESET[TXN_TXN_PENDING_BIT];
         aux_meta_q <= DEV_STATUS_RESET[AUX_PWR_BIT];
         aux_power_detected_q <= DEV_STATUS_RESET[AUX_PWR_BIT];
      end else begin
         txn_pending_q <= np_outstanding_in; // R3
         aux_meta_q <= aux_power_pin_in;
         aux_power_detected_q <= aux_meta_q; // R4
      end
   end

   // Messages and read data
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         err_nonfatal_msg_q <= 1'b0;
         err_cor_msg_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         err_nonfatal_msg_q <= nonfatal_msg_d;
         err_cor_msg_q <= cor_msg_d;
         rvalid_q <= cfg_rd_in;
         if (cfg_rd_in) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign cfg_rdata_out = rdata_q;
   assign cfg_rvalid_out = rvalid_q;
   assign err_nonfatal_msg_out = err_nonfatal_msg_q;
   assign err_cor_msg_out = err_cor_msg_q;
   assign nonfatal_report_en_out = nonfatal_report_en_q;
   assign correctable_report_en_out = correctable_report_en_q;
   assign unsupported_req_report_en_out = unsupported_req_report_en_q;
endmodule // pdslc_regs
`default_nettype wire
